// ### rtl/pdm_pkg.sv
// Purpose: constants and types for the always-on power domain mode manager
// Assumes: APB slave, 32-bit data, pclk at 50 MHz
// Notes:   register layout and field positions below
package pdm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] PDM_OFF_MODE   = 12'h000;
  localparam logic [11:0] PDM_OFF_IOCFG  = 12'h004;
  localparam logic [11:0] PDM_OFF_CMP    = 12'h008;
  localparam logic [11:0] PDM_OFF_DROOP  = 12'h00C;
  localparam logic [11:0] PDM_OFF_DRPEN  = 12'h010;
  localparam logic [11:0] PDM_OFF_STATUS = 12'h014;
  localparam logic [11:0] PDM_OFF_WLAN   = 12'h018;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          PDM_NUM_IO      = 5;
  localparam int          PDM_IOCFG_OFF   = 5;
  localparam int          PDM_IOCFG_RUN   = 10;
  localparam logic [4:0]  PDM_RST_VSEL    = 5'h00;
  localparam logic [4:0]  PDM_RST_OFF     = 5'h00;
  localparam logic [4:0]  PDM_RST_RUN     = 5'h1F;
  localparam int          PDM_CMP_DIFF    = 0;
  localparam int          PDM_CMP_IRQEN   = 1;
  localparam int          PDM_CMP_WAKEEN  = 2;
  localparam int          PDM_CMP_REF     = 4;
  localparam int          PDM_CMP_ON      = 3;
  localparam int          PDM_ST_CMP      = 0;
  localparam int          PDM_ST_WAKE     = 1;
  localparam int          PDM_ST_MCU      = 4;
  localparam int          PDM_ST_WLAN     = 8;
  localparam int          PDM_ST_SYS      = 12;
  localparam logic [7:0]  PDM_RST_REF     = 8'h00;
  localparam logic [7:0]  PDM_RST_DROOP   = 8'h00;

  // ----------------------------------------------------------------
  // power mode field codes and states
  // ----------------------------------------------------------------
  localparam logic [1:0]  PDM_SEL_ACTIVE  = 2'h0;
  localparam logic [1:0]  PDM_SEL_STANDBY = 2'h1;
  localparam logic [1:0]  PDM_SEL_SLEEP   = 2'h2;
  localparam logic [1:0]  PDM_SEL_SHUTOFF = 2'h3;

  typedef enum logic [2:0] {
    MCU_ACTIVE_STATE     = 3'b000,
    MCU_IDLE_STATE       = 3'b001,
    MCU_STANDBY_STATE    = 3'b010,
    MCU_SLEEP_STATE      = 3'b011,
    MCU_DEEP_SLEEP_STATE = 3'b100,
    MCU_SHUTDOWN_STATE   = 3'b101
  } pdm_mcu_t;

  typedef enum logic [1:0] {
    WLAN_ACTIVE_STATE     = 2'b00,
    WLAN_DEEP_SLEEP_STATE = 2'b01,
    WLAN_SHUTDOWN_STATE   = 2'b10
  } pdm_wlan_t;

endpackage

// ### rtl/pdm_power_manager.sv
// Purpose: always-on power manager: mode select, domain power, pads, comparator, droop reset
// Assumes: presetn is the always-on reset, never driven by the droop reset
// Notes:   system mode code is mcu state times four plus wlan state
module pdm_power_manager
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          cpu_wfi,
  input  wire logic                          cpu_deep_sleep,
  input  wire logic                          wake_event,
  input  wire logic                          cmp_raw_out,
  input  wire logic                          droop_raw,
  input  wire logic [pdm_pkg::PDM_NUM_IO-1:0] pad_oe_in,
  output logic [pdm_pkg::PDM_NUM_IO-1:0]     pad_oe_out,
  output logic [pdm_pkg::PDM_NUM_IO-1:0]     pad_domain_off,
  output logic [pdm_pkg::PDM_NUM_IO-1:0]     pad_low_voltage_sel,
  output logic [pdm_pkg::PDM_NUM_IO-1:0]     pad_regulator_run,
  output logic                               mem_domain_on,
  output logic                               core_domain_on,
  output logic                               wlan_domain_on,
  output logic                               always_on_domain_on,
  output logic                               cmp_diff_mode,
  output logic [7:0]                         cmp_ref_sel,
  output logic                               cmp_enable,
  output logic                               cmp_irq,
  output logic                               wake_req,
  output logic [7:0]                         droop_setup,
  output logic                               core_reset_n
);
  import pdm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mode_sel;
    pdm_mcu_t    mcu;
    pdm_wlan_t   wlan;
    logic        full_shutdown;
    logic [4:0]  vsel;
    logic [4:0]  off;
    logic [4:0]  run;
    logic [11:0] cmp_ctrl;
    logic [7:0]  droop;
    logic        droop_rst_en;
    logic        cmp_flag;
    logic        wake_flag;
    logic [2:0]  cmp_sync;
    logic        cmp_level;
    logic [2:0]  droop_sync;
    logic        droop_level;
    logic [2:0]  wake_sync;
    logic        wake_level;
    logic        wake_prev;
    logic        cmp_prev;
    logic [31:0] rdata;
  } pdm_state_t;

  pdm_state_t s_q;
  pdm_state_t s_d;

  logic access;
  logic wr;
  logic cmp_rise;
  logic wake_rise;

  assign access = psel & penable;
  assign wr     = access & pwrite;

  // system mode code: mcu state in upper bits, wlan state below
  function automatic logic [4:0] sys_mode(input pdm_mcu_t m, input pdm_wlan_t w);
    sys_mode = {m, w};
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // three-stage synchronisers on asynchronous inputs
    s_d.cmp_sync   = {s_q.cmp_sync[1:0], cmp_raw_out};
    s_d.droop_sync = {s_q.droop_sync[1:0], droop_raw};
    s_d.wake_sync  = {s_q.wake_sync[1:0], wake_event};
    if (s_q.cmp_sync[1] == s_q.cmp_sync[2])
    begin
      s_d.cmp_level = s_q.cmp_sync[2];
    end
    if (s_q.droop_sync[1] == s_q.droop_sync[2])
    begin
      s_d.droop_level = s_q.droop_sync[2];
    end
    if (s_q.wake_sync[1] == s_q.wake_sync[2])
    begin
      s_d.wake_level = s_q.wake_sync[2];
    end
    s_d.cmp_prev  = s_q.cmp_level;
    s_d.wake_prev = s_q.wake_level;

    // comparator event latches when enabled; set wins over clear
    if (wr && paddr == PDM_OFF_STATUS)
    begin
      if (pwdata[PDM_ST_CMP])
      begin
        s_d.cmp_flag = 1'b0;
      end
      if (pwdata[PDM_ST_WAKE])
      begin
        s_d.wake_flag = 1'b0;
      end
    end
    if (cmp_rise && s_q.cmp_ctrl[PDM_CMP_ON])
    begin
      s_d.cmp_flag = 1'b1;
    end
    if ((cmp_rise && s_q.cmp_ctrl[PDM_CMP_ON] && s_q.cmp_ctrl[PDM_CMP_WAKEEN]) || wake_rise)
    begin
      s_d.wake_flag = 1'b1;
    end

    // register writes
    if (wr)
    begin
      if (paddr == PDM_OFF_MODE)
      begin
        s_d.mode_sel = pwdata[1:0];
      end
      else if (paddr == PDM_OFF_IOCFG)
      begin
        s_d.vsel = pwdata[4:0];
        s_d.off  = pwdata[PDM_IOCFG_OFF +: PDM_NUM_IO];
        s_d.run  = pwdata[PDM_IOCFG_RUN +: PDM_NUM_IO];
      end
      else if (paddr == PDM_OFF_CMP)
      begin
        s_d.cmp_ctrl = pwdata[11:0];
      end
      else if (paddr == PDM_OFF_DROOP)
      begin
        s_d.droop = pwdata[7:0];
      end
      else if (paddr == PDM_OFF_DRPEN)
      begin
        s_d.droop_rst_en = pwdata[0];
      end
      else if (paddr == PDM_OFF_WLAN)
      begin
        if (pwdata[1:0] <= 2'h2)
        begin
          s_d.wlan = pdm_wlan_t'(pwdata[1:0]);
        end
        s_d.full_shutdown = pwdata[4];
      end
    end

    // mcu state machine
    case (s_q.mcu)
      MCU_ACTIVE_STATE:
      begin
        if (cpu_wfi && !cpu_deep_sleep)
        begin
          s_d.mcu = MCU_IDLE_STATE;
        end
        else if (cpu_wfi && cpu_deep_sleep)
        begin
          if (s_q.mode_sel == PDM_SEL_STANDBY)
          begin
            s_d.mcu = MCU_STANDBY_STATE;
          end
          else if (s_q.mode_sel == PDM_SEL_SLEEP)
          begin
            s_d.mcu = MCU_SLEEP_STATE;
          end
          else if (s_q.mode_sel == PDM_SEL_SHUTOFF)
          begin
            s_d.mcu = s_q.full_shutdown && s_q.wlan == WLAN_SHUTDOWN_STATE
                      ? MCU_SHUTDOWN_STATE : MCU_DEEP_SLEEP_STATE;
          end
        end
      end
      MCU_IDLE_STATE:
      begin
        if (!cpu_wfi || s_q.wake_flag)
        begin
          s_d.mcu = MCU_ACTIVE_STATE;
        end
      end
      default:
      begin
        // wake-up from low-power states
        if (s_q.wake_flag)
        begin
          s_d.mcu = MCU_ACTIVE_STATE;
        end
      end
    endcase

    // read data
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == PDM_OFF_MODE)
      begin
        s_d.rdata = {30'h0, s_q.mode_sel};
      end
      else if (paddr == PDM_OFF_IOCFG)
      begin
        s_d.rdata = {17'h0, s_q.run, s_q.off, s_q.vsel};
      end
      else if (paddr == PDM_OFF_CMP)
      begin
        s_d.rdata = {20'h0, s_q.cmp_ctrl};
      end
      else if (paddr == PDM_OFF_DROOP)
      begin
        s_d.rdata = {24'h0, s_q.droop};
      end
      else if (paddr == PDM_OFF_DRPEN)
      begin
        s_d.rdata = {31'h0, s_q.droop_rst_en};
      end
      else if (paddr == PDM_OFF_STATUS)
      begin
        s_d.rdata = {15'h0, sys_mode(s_q.mcu, s_q.wlan), 2'h0, s_q.wlan,
                     1'b0, s_q.mcu, 1'b0, s_q.cmp_level, s_q.wake_flag, s_q.cmp_flag};
      end
      else if (paddr == PDM_OFF_WLAN)
      begin
        s_d.rdata = {27'h0, s_q.full_shutdown, 2'h0, s_q.wlan};
      end
    end
  end

  assign cmp_rise  = s_q.cmp_level & ~s_q.cmp_prev;
  assign wake_rise = s_q.wake_level & ~s_q.wake_prev;

  // ----------------------------------------------------------------
  // state register, reset only by the always-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q      <= '0;
      s_q.mode_sel <= PDM_SEL_ACTIVE;
      s_q.mcu  <= MCU_ACTIVE_STATE;
      s_q.wlan <= WLAN_ACTIVE_STATE;
      s_q.vsel <= PDM_RST_VSEL;
      s_q.off  <= PDM_RST_OFF;
      s_q.run  <= PDM_RST_RUN;
      s_q.cmp_ctrl <= '0;
      s_q.droop <= PDM_RST_DROOP;
      s_q.droop_rst_en <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // pads of an off domain are tri-stated
  assign pad_oe_out          = pad_oe_in & ~s_q.off;
  assign pad_domain_off      = s_q.off;
  assign pad_low_voltage_sel = s_q.vsel;
  assign pad_regulator_run   = s_q.run;
  // domain power per mcu state, wlan domain power per wlan state
  assign mem_domain_on  = s_q.mcu <= MCU_SLEEP_STATE;
  assign core_domain_on = s_q.mcu <= MCU_STANDBY_STATE;
  assign wlan_domain_on = s_q.wlan == WLAN_ACTIVE_STATE;
  assign always_on_domain_on = 1'b1;
  // comparator configuration
  assign cmp_diff_mode = s_q.cmp_ctrl[PDM_CMP_DIFF];
  assign cmp_ref_sel   = s_q.cmp_ctrl[PDM_CMP_REF +: 8];
  assign cmp_enable    = s_q.cmp_ctrl[PDM_CMP_ON];
  assign cmp_irq       = s_q.cmp_flag & s_q.cmp_ctrl[PDM_CMP_IRQEN];
  assign wake_req      = s_q.wake_flag;
  assign droop_setup   = s_q.droop;
  // droop reset only hits core side, gated by enable
  assign core_reset_n  = ~(s_q.droop_level & s_q.droop_rst_en);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_core_off;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu >= MCU_SLEEP_STATE |-> !core_domain_on;
  endproperty
  a_core_off: assert property (p_core_off) else $error("core on in sleep");

  property p_mem_off;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu >= MCU_DEEP_SLEEP_STATE |-> !mem_domain_on;
  endproperty
  a_mem_off: assert property (p_mem_off) else $error("memory on in deep");

  property p_tristate;
    @(posedge pclk) disable iff (!presetn)
      (pad_domain_off & pad_oe_out) == 5'h00;
  endproperty
  a_tristate: assert property (p_tristate) else $error("off pad driven");

  property p_standby;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu == MCU_ACTIVE_STATE && cpu_wfi && cpu_deep_sleep
      && s_q.mode_sel == PDM_SEL_STANDBY |=> s_q.mcu == MCU_STANDBY_STATE;
  endproperty
  a_standby: assert property (p_standby) else $error("standby missed");

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu == MCU_ACTIVE_STATE && cpu_wfi && cpu_deep_sleep
      && s_q.mode_sel == PDM_SEL_SLEEP |=> s_q.mcu == MCU_SLEEP_STATE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep missed");

  property p_shutoff;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu == MCU_ACTIVE_STATE && cpu_wfi && cpu_deep_sleep
      && s_q.mode_sel == PDM_SEL_SHUTOFF |=> s_q.mcu >= MCU_DEEP_SLEEP_STATE;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("shut-off missed");

  property p_droop_gate;
    @(posedge pclk) disable iff (!presetn)
      !s_q.droop_rst_en |-> core_reset_n;
  endproperty
  a_droop_gate: assert property (p_droop_gate) else $error("droop reset while off");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      $rose(s_q.cmp_flag) |-> $past(s_q.cmp_ctrl[PDM_CMP_ON]);
  endproperty
  a_irq: assert property (p_irq) else $error("comparator event while off");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      s_q.mcu >= MCU_STANDBY_STATE && s_q.wake_flag |=> s_q.mcu == MCU_ACTIVE_STATE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up missed");

  c_standby: cover property (@(posedge pclk) s_q.mcu == MCU_STANDBY_STATE);
  c_sleep:   cover property (@(posedge pclk) s_q.mcu == MCU_SLEEP_STATE);
  c_irq:     cover property (@(posedge pclk) cmp_irq);
  c_droop:   cover property (@(posedge pclk) !core_reset_n);

endmodule

// ### sim/tb_pdm_power_manager.sv
// Purpose: self-checking bench for the always-on power domain mode manager
// Assumes: APB slave answers with pready, pclk at 50 MHz, presetn async active low
// Notes:   expected values come from the package field layout and mode codes
module tb_pdm_power_manager;
  timeunit 1ns;
  timeprecision 1ps;
  import pdm_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  cpu_wfi = 1'b0;
  logic                  cpu_deep_sleep = 1'b0;
  logic                  wake_event = 1'b0;
  logic                  cmp_raw_out = 1'b0;
  logic                  droop_raw = 1'b0;
  logic [PDM_NUM_IO-1:0] pad_oe_in = 5'h1F;
  logic [PDM_NUM_IO-1:0] pad_oe_out;
  logic [PDM_NUM_IO-1:0] pad_domain_off;
  logic [PDM_NUM_IO-1:0] pad_low_voltage_sel;
  logic [PDM_NUM_IO-1:0] pad_regulator_run;
  logic                  mem_domain_on;
  logic                  core_domain_on;
  logic                  wlan_domain_on;
  logic                  always_on_domain_on;
  logic                  cmp_diff_mode;
  logic [7:0]            cmp_ref_sel;
  logic                  cmp_enable;
  logic                  cmp_irq;
  logic                  wake_req;
  logic [7:0]            droop_setup;
  logic                  core_reset_n;
  logic [31:0]           rdata;
  int                    bad_count = 0;
  int                    n_compared = 0;
  int                    cycles = 0;
  int                    k;
  logic [2:0]            exp_mcu [3] = '{3'h2, 3'h3, 3'h4};
  logic [1:0]            exp_dom [3] = '{2'b11, 2'b10, 2'b00};

  // ----------------------------------------------------------------
  // clock, watchdog and design
  // ----------------------------------------------------------------
  always #10 pclk = ~pclk;

  // cut a hang short well beyond the expected run length
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  pdm_power_manager DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_wfi(cpu_wfi), .cpu_deep_sleep(cpu_deep_sleep), .wake_event(wake_event),
    .cmp_raw_out(cmp_raw_out), .droop_raw(droop_raw), .pad_oe_in(pad_oe_in),
    .pad_oe_out(pad_oe_out), .pad_domain_off(pad_domain_off),
    .pad_low_voltage_sel(pad_low_voltage_sel), .pad_regulator_run(pad_regulator_run),
    .mem_domain_on(mem_domain_on), .core_domain_on(core_domain_on),
    .wlan_domain_on(wlan_domain_on), .always_on_domain_on(always_on_domain_on),
    .cmp_diff_mode(cmp_diff_mode), .cmp_ref_sel(cmp_ref_sel), .cmp_enable(cmp_enable),
    .cmp_irq(cmp_irq), .wake_req(wake_req), .droop_setup(droop_setup),
    .core_reset_n(core_reset_n)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of registers and domain outputs
    apb(1'b0, PDM_OFF_IOCFG, 32'h0);
    chk(rdata, 32'h0000_7C00, "io cfg reset");
    chk(32'(pad_regulator_run), 32'h1F, "regulator run reset");
    apb(1'b0, PDM_OFF_MODE, 32'h0);
    chk(rdata, 32'h0, "mode reset");
    apb(1'b0, PDM_OFF_DRPEN, 32'h0);
    chk(rdata, 32'h0, "droop enable reset");
    chk(32'({mem_domain_on, core_domain_on}), 32'h3, "domains in active");
    chk(32'({wlan_domain_on, pslverr}), 32'h2, "wlan on, no error");
    // unmapped place reads zero and ignores writes
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk(rdata, 32'h0, "unmapped read");
    // domains 1 and 3 off, voltage selects and regulator power-down
    apb(1'b1, PDM_OFF_IOCFG, 32'h0000_0145);
    chk(32'(pad_domain_off), 32'h0A, "domains 1 and 3 off");
    chk(32'(pad_oe_out), 32'h15, "pads tri-stated");
    chk(32'(pad_low_voltage_sel), 32'h05, "voltage select");
    chk(32'(pad_regulator_run), 32'h00, "regulator down");
    apb(1'b1, PDM_OFF_IOCFG, 32'h0000_7C00);
    chk(32'(pad_oe_out), 32'h1F, "pads restored");
    // droop gated until enabled, then resets core only
    droop_raw <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(core_reset_n), 32'h1, "droop gated");
    apb(1'b1, PDM_OFF_DROOP, 32'h0000_005A);
    chk(32'(droop_setup), 32'h5A, "droop setup");
    apb(1'b1, PDM_OFF_DRPEN, 32'h1);
    for (k = 0; k < 10 && core_reset_n !== 1'b0; k++) @(posedge pclk);
    chk(32'(core_reset_n), 32'h0, "droop reset");
    apb(1'b0, PDM_OFF_DROOP, 32'h0);
    chk(rdata, 32'h5A, "manager survives droop");
    droop_raw <= 1'b0;
    for (k = 0; k < 10 && core_reset_n !== 1'b1; k++) @(posedge pclk);
    chk(32'(core_reset_n), 32'h1, "droop released");
    // comparator differential then single-ended with reference
    pad_oe_in <= 5'h0F;
    apb(1'b1, PDM_OFF_CMP, 32'h0000_0A5B);
    chk(32'({cmp_diff_mode, cmp_enable, cmp_ref_sel}), 32'h3A5, "cmp diff");
    cmp_raw_out <= 1'b1;
    for (k = 0; k < 20 && cmp_irq !== 1'b1; k++) @(posedge pclk);
    chk(32'(cmp_irq), 32'h1, "cmp irq");
    chk(32'(wake_req), 32'h0, "wake not enabled");
    apb(1'b1, PDM_OFF_STATUS, 32'h1);
    chk(32'(cmp_irq), 32'h0, "cmp irq cleared");
    apb(1'b1, PDM_OFF_CMP, 32'h0000_03CC);
    chk(32'({cmp_diff_mode, cmp_enable, cmp_ref_sel}), 32'h13C, "cmp single");
    cmp_raw_out <= 1'b0;
    for (k = 0; k < 20 && wake_req !== 1'b1; k++) @(posedge pclk);
    chk(32'(wake_req), 32'h0, "wake on rising only");
    apb(1'b1, PDM_OFF_CMP, 32'h0);
    pad_oe_in <= 5'h1F;
    // idle entry and exit; status is captured in the setup cycle
    cpu_wfi <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PDM_OFF_STATUS, 32'h0);
    chk(32'(rdata[6:4]), 32'(MCU_IDLE_STATE), "idle");
    cpu_wfi <= 1'b0;
    @(posedge pclk);
    apb(1'b0, PDM_OFF_STATUS, 32'h0);
    chk(32'(rdata[6:4]), 32'(MCU_ACTIVE_STATE), "idle exit");
    // standby, sleep, deep sleep and full shutdown by mode code, then wake
    for (int m = 1; m < 5; m++)
    begin
      apb(1'b1, PDM_OFF_IOCFG, 32'h0000_01E0);
      if (m == 4)
        apb(1'b1, PDM_OFF_WLAN, 32'h12);
      apb(1'b1, PDM_OFF_MODE, (m == 4) ? 32'h3 : 32'(m));
      cpu_deep_sleep <= 1'b1;
      cpu_wfi        <= 1'b1;
      @(posedge pclk);
      cpu_wfi        <= 1'b0;
      apb(1'b0, PDM_OFF_STATUS, 32'h0);
      chk(32'(pad_oe_out), 32'h10, "pads off in low power");
      if (m == 4)
      begin
        chk(32'(rdata[16:8]), 32'h162, "full shutdown mode");
        chk(32'(wlan_domain_on), 32'h0, "wlan domain off");
      end
      else
      begin
        chk(32'(rdata[16:4]), (32'(exp_mcu[m-1]) << 10) | 32'(exp_mcu[m-1]),
            "mcu and system mode");
        chk(32'({mem_domain_on, core_domain_on}), 32'(exp_dom[m-1]), "domains");
      end
      chk(32'(always_on_domain_on), 32'h1, "always-on stays");
      wake_event <= 1'b1;
      for (k = 0; k < 20 && wake_req !== 1'b1; k++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      wake_event     <= 1'b0;
      cpu_deep_sleep <= 1'b0;
      apb(1'b0, PDM_OFF_STATUS, 32'h0);
      chk(32'(rdata[6:4]), 32'(MCU_ACTIVE_STATE), "woken");
      apb(1'b1, PDM_OFF_STATUS, 32'h2);
      chk(32'(wake_req), 32'h0, "wake flag cleared");
      apb(1'b1, PDM_OFF_IOCFG, 32'h0000_7C00);
    end
    tally_and_finish();
  end
endmodule
